// file: hw/eie_pkg.sv
// package for the external interrupt edge and acknowledge block
// assumes a single 40 MHz core clock with a synchronous active-high reset
//
// Contract
// [RL1] An access to the port direction or pin option register blanks the edge detector for one clock cycle.
// [RL2] An edge that arrives during the blanking cycle is neither detected nor raised as a request.
// [RL3] A request taken while the condition code restore instruction executes yields the reset vector.
// [RL4] A request that coincides with software clearing its flag may produce an unwanted reset.
// [RL5] Clearing a source's mask while its request is active never produces the unwanted reset.
// [RL6] Clearing a flag inside its own routine, or any routine when not nested, never produces it.
// [RL7] When nested, clearing a flag in a routine of equal or higher level never produces it.
// [RL8] Clearing a flag while that source is disabled never produces the unwanted reset.
// [RL9] Software sets the global mask right before each condition code restore instruction.
// [RL10] Outside interrupt context, software sets the global mask around clearing an active flag.
// [RL11] When nested, software saves codes, sets the mask, clears the flag, then restores codes.
// [RL12] While the global mask is set all maskable requests are held off, and taken again once clear.
// [RL13] Each pin's programmed sensitivity decides which transition sets its request.
package eie_pkg;
  // ==========================================================
  // sizes and reset values
  localparam int          EIE_NUM_SRC     = 4;
  localparam int          EIE_VEC_W       = 4;
  localparam int          EIE_LVL_W       = 2;
  localparam int          EIE_BLANK_CYC   = 1;
  localparam logic [3:0]  EIE_RESET_VEC   = 4'hF;
  localparam logic [3:0]  EIE_VEC_BASE    = 4'h1;
  localparam logic [1:0]  EIE_LVL_IDLE    = 2'h0;

  // ==========================================================
  // pin sensitivity encoding
  typedef enum logic [1:0] {
    EIE_SENS_FALL_LOW = 2'h0,
    EIE_SENS_RISE     = 2'h1,
    EIE_SENS_FALL     = 2'h2,
    EIE_SENS_BOTH     = 2'h3
  } eie_sens_type;
endpackage

// file: hw/eie_edge_if.sv
// carrier between the edge detector and the controller
// assumes one clock domain
`timescale 1ns/10ps
interface eie_edge_if #(parameter int N = 4);
  logic [N-1:0] edge_hit;
  modport det  (output edge_hit);
  modport ctrl (input  edge_hit);
endinterface

// file: hw/eie_edge_det.sv
// per-pin edge detector with configuration-access blanking
// assumes pins already synchronous to the core clock
`timescale 1ns/10ps
module eie_edge_det
  import eie_pkg::*;
#(
  parameter int N = EIE_NUM_SRC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [N-1:0]     pin_i,
  input  wire logic [2*N-1:0]   sens_i,
  input  wire logic             blank_i,
  eie_edge_if.det               ev
);
  logic [N-1:0] pin_d_r;
  logic [N-1:0] hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_d_r <= '1;
    end else begin
      pin_d_r <= pin_i;
    end
  end

  // ==========================================================
  // sensitivity decode
  for (genvar g = 0; g < N; g++) begin : g_pin
    wire       rise = pin_i[g] & ~pin_d_r[g];
    wire       fall = ~pin_i[g] & pin_d_r[g];
    wire [1:0] s    = sens_i[2*g +: 2];
    assign hit[g] = (s == EIE_SENS_FALL_LOW) ? (fall | ~pin_i[g]) : // RL13
                    (s == EIE_SENS_RISE)     ? rise :
                    (s == EIE_SENS_FALL)     ? fall :
                                               (rise | fall);
  end

  assign ev.edge_hit = blank_i ? '0 : hit; // RL1 RL2

  a_blank_masks_hit: assert property (@(posedge clk_i) // RL2
    disable iff (rst_i) blank_i |-> ev.edge_hit == '0)
    else $error("edge seen during blanking");
endmodule

// file: hw/eie_top.sv
// interrupt controller: pending flags, masking, vector hand-off
// assumes cpu strobes are one-cycle pulses synchronous to CORE_CLK_I
`timescale 1ns/10ps
module eie_top
  import eie_pkg::*;
#(
  parameter int N = EIE_NUM_SRC
) (
  // clock and reset
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      SYS_RST_I,
  // pins and configuration
  input  wire logic [N-1:0]              PIN_I,
  input  wire logic [2*N-1:0]            PIN_SENS_I,
  input  wire logic                      PORT_CFG_ACCESS_I,
  input  wire logic [N-1:0]              SRC_EN_I,
  input  wire logic [2*N-1:0]            SRC_LVL_I,
  input  wire logic [N-1:0]              FLAG_CLR_I,
  // cpu side
  input  wire logic                      GLOBAL_MASK_I,
  input  wire logic                      CC_RESTORE_I,
  input  wire logic                      IN_ISR_I,
  input  wire logic                      NESTED_MODE_I,
  input  wire logic [eie_pkg::EIE_LVL_W-1:0] CUR_LVL_I,
  input  wire logic                      VEC_ACK_I,
  output logic                           IRQ_O,
  output logic [eie_pkg::EIE_VEC_W-1:0]  VEC_O,
  output logic [N-1:0]                   PEND_O,
  output logic                           RESET_FETCH_O
);
  import eie_pkg::*;

  eie_edge_if #(.N(N)) ev ();

  logic [N-1:0]         pend_r, pend_nxt;
  logic                 irq_r;
  logic [EIE_VEC_W-1:0] vec_r, vec_nxt;
  logic                 rstf_r;
  logic [N-1:0]         armed;
  logic [N-1:0]         hazard;
  logic [N-1:0]         lvl_ok;
  logic                 any_req;
  logic [EIE_VEC_W-1:0] sel_vec;

  eie_edge_det #(.N(N)) u_det (
    .clk_i   (CORE_CLK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (PIN_I),
    .sens_i  (PIN_SENS_I),
    .blank_i (PORT_CFG_ACCESS_I), // RL1
    .ev      (ev)
  );

  // ==========================================================
  // pending flags: a new edge wins over a clear
  assign pend_nxt = (pend_r & ~FLAG_CLR_I) | ev.edge_hit;

  // ==========================================================
  // unsafe clear detection
  for (genvar g = 0; g < N; g++) begin : g_src
    wire [EIE_LVL_W-1:0] lvl = SRC_LVL_I[EIE_LVL_W*g +: EIE_LVL_W];
    wire safe_ctx = ~SRC_EN_I[g]                              // RL8 RL5
                  | GLOBAL_MASK_I                              // RL10
                  | (IN_ISR_I & ~NESTED_MODE_I)                // RL6
                  | (IN_ISR_I & NESTED_MODE_I & lvl_ok[g]);    // RL7
    assign lvl_ok[g] = (CUR_LVL_I >= lvl);
    assign armed[g]  = pend_r[g] & SRC_EN_I[g];
    assign hazard[g] = FLAG_CLR_I[g] & ev.edge_hit[g] & SRC_EN_I[g]
                     & ~safe_ctx; // RL4
  end

  // ==========================================================
  // vector selection, lowest index first
  assign any_req = |armed & ~GLOBAL_MASK_I; // RL12
  always_comb begin
    sel_vec = EIE_RESET_VEC;
    for (int i = N - 1; i >= 0; i--) begin
      if (armed[i]) begin
        sel_vec = EIE_VEC_BASE + EIE_VEC_W'(i);
      end
    end
  end
  assign vec_nxt = (CC_RESTORE_I | (|hazard)) ? EIE_RESET_VEC // RL3 RL4
                                               : sel_vec;

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      pend_r <= '0;
      irq_r  <= 1'b0;
      vec_r  <= EIE_RESET_VEC;
      rstf_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      irq_r  <= any_req & ~VEC_ACK_I;
      vec_r  <= vec_nxt;
      rstf_r <= (any_req & CC_RESTORE_I) | (|hazard); // RL3 RL4
    end
  end

  assign IRQ_O         = irq_r;
  assign VEC_O         = vec_r;
  assign PEND_O        = pend_r;
  assign RESET_FETCH_O = rstf_r;

  // ==========================================================
  // named steps shared by the checks
  sequence seq_armed_open;
    !GLOBAL_MASK_I && |armed && !VEC_ACK_I;
  endsequence

  sequence seq_irq_up;
    IRQ_O;
  endsequence

  sequence seq_restore_hit;
    CC_RESTORE_I && any_req;
  endsequence

  sequence seq_reset_fetch;
    RESET_FETCH_O && VEC_O == EIE_RESET_VEC;
  endsequence

  sequence seq_nest_safe;
    IN_ISR_I && NESTED_MODE_I && !CC_RESTORE_I
      && (FLAG_CLR_I & ~lvl_ok) == '0;
  endsequence

  // ==========================================================
  // global checks
  a_mask_holds_irq: assert property (@(posedge CORE_CLK_I) // RL12
    disable iff (SYS_RST_I) GLOBAL_MASK_I |=> !IRQ_O)
    else $error("irq raised while masked");

  a_unmask_raises: assert property (@(posedge CORE_CLK_I) // RL12
    disable iff (SYS_RST_I) seq_armed_open |=> seq_irq_up)
    else $error("armed request not raised");

  a_ack_drops_irq: assert property (@(posedge CORE_CLK_I) // RL12
    disable iff (SYS_RST_I) VEC_ACK_I |=> !IRQ_O)
    else $error("irq kept after vector take");

  a_restore_rst_vec: assert property (@(posedge CORE_CLK_I) // RL3
    disable iff (SYS_RST_I) seq_restore_hit |=> seq_reset_fetch)
    else $error("restore collision missed reset vector");

  a_hazard_fetch: assert property (@(posedge CORE_CLK_I) // RL4
    disable iff (SYS_RST_I) (|hazard) |=> seq_reset_fetch)
    else $error("hazard did not fetch reset");

  a_mask_clear_safe: assert property (@(posedge CORE_CLK_I) // RL5 RL8
    disable iff (SYS_RST_I)
    ((FLAG_CLR_I & SRC_EN_I) == '0 && !CC_RESTORE_I) |=> !RESET_FETCH_O)
    else $error("spurious reset fetch");

  a_masked_clr_safe: assert property (@(posedge CORE_CLK_I) // RL10
    disable iff (SYS_RST_I)
    (GLOBAL_MASK_I && !CC_RESTORE_I) |=> !RESET_FETCH_O)
    else $error("reset fetch under mask");

  a_isr_clr_safe: assert property (@(posedge CORE_CLK_I) // RL6
    disable iff (SYS_RST_I)
    (IN_ISR_I && !NESTED_MODE_I && !CC_RESTORE_I) |=> !RESET_FETCH_O)
    else $error("reset fetch in isr");

  a_nest_clr_safe: assert property (@(posedge CORE_CLK_I) // RL7
    disable iff (SYS_RST_I) seq_nest_safe |=> !RESET_FETCH_O)
    else $error("reset fetch in nested routine");

  // ==========================================================
  // per-source checks
  for (genvar g = 0; g < N; g++) begin : g_chk
    wire [1:0] sens_g = PIN_SENS_I[2*g +: 2];

    sequence seq_blank_end;
      PORT_CFG_ACCESS_I ##1 (!PORT_CFG_ACCESS_I && ev.edge_hit[g]);
    endsequence

    a_blank_one_cyc: assert property (@(posedge CORE_CLK_I) // RL1
      disable iff (SYS_RST_I) seq_blank_end |=> PEND_O[g])
      else $error("edge lost after blanking cycle");

    a_blank_no_pend: assert property (@(posedge CORE_CLK_I) // RL2
      disable iff (SYS_RST_I)
      (PORT_CFG_ACCESS_I && !PEND_O[g]) |=> !PEND_O[g])
      else $error("pend set during blanking");

    a_fall_sets_pend: assert property (@(posedge CORE_CLK_I) // RL13
      disable iff (SYS_RST_I)
      (!$past(SYS_RST_I) && !PORT_CFG_ACCESS_I && sens_g == EIE_SENS_FALL
        && $fell(PIN_I[g])) |=> PEND_O[g])
      else $error("falling edge not pended");

    a_rise_sets_pend: assert property (@(posedge CORE_CLK_I) // RL13
      disable iff (SYS_RST_I)
      (!$past(SYS_RST_I) && !PORT_CFG_ACCESS_I && sens_g == EIE_SENS_RISE
        && $rose(PIN_I[g])) |=> PEND_O[g])
      else $error("rising edge not pended");

    a_both_sets_pend: assert property (@(posedge CORE_CLK_I) // RL13
      disable iff (SYS_RST_I)
      (!$past(SYS_RST_I) && !PORT_CFG_ACCESS_I && sens_g == EIE_SENS_BOTH
        && $changed(PIN_I[g])) |=> PEND_O[g])
      else $error("any edge not pended");

    a_rise_skips_fall: assert property (@(posedge CORE_CLK_I) // RL13
      disable iff (SYS_RST_I)
      (sens_g == EIE_SENS_RISE && $fell(PIN_I[g]) && !PEND_O[g])
        |=> !PEND_O[g])
      else $error("falling edge pended on rising pin");

    a_low_holds_pend: assert property (@(posedge CORE_CLK_I) // RL13
      disable iff (SYS_RST_I)
      (!PORT_CFG_ACCESS_I && sens_g == EIE_SENS_FALL_LOW && !PIN_I[g])
        |=> PEND_O[g])
      else $error("low level not pended");

    a_pend_holds: assert property (@(posedge CORE_CLK_I) // RL12
      disable iff (SYS_RST_I)
      (PEND_O[g] && !FLAG_CLR_I[g]) |=> PEND_O[g])
      else $error("pending flag lost without clear");

    a_clr_drops_pend: assert property (@(posedge CORE_CLK_I) // RL4
      disable iff (SYS_RST_I)
      (FLAG_CLR_I[g] && !ev.edge_hit[g]) |=> !PEND_O[g])
      else $error("pending flag kept after clear");
  end
endmodule

// file: tb/eie_cpu_model.sv
// cpu core model: vector take, global mask, code restore
// assumes its tasks are called just after a falling edge
`timescale 1ns/10ps
module eie_cpu_model (
  // clock and request
  input  wire logic clk_i,
  input  wire logic irq_i,
  // cpu strobes
  output logic      ack_o,
  output logic      mask_o,
  output logic      cc_rst_o
);
  // ======================================
  // idle levels
  initial begin
    ack_o    = 1'b0;
    mask_o   = 1'b0;
    cc_rst_o = 1'b0;
  end
  // ======================================
  // vector take: the core masks on entry
  task take_vector;
    ack_o  = irq_i;
    mask_o = 1'b1;
    @(negedge clk_i);
    ack_o  = 1'b0;
  endtask
  // ======================================
  // mask and condition code restore
  task set_mask(input logic m);
    mask_o = m;
  endtask
  task restore_cc(input logic guard);
    logic prev;
    prev = mask_o;
    if (guard) begin
      mask_o = 1'b1;
      @(negedge clk_i);
    end
    cc_rst_o = 1'b1;
    @(negedge clk_i);
    cc_rst_o = 1'b0;
    mask_o   = prev;
  endtask
endmodule

// file: tb/ext_interrupt_edge_and_ack_bench.sv
// bench for the edge detector and vector hand-off
// assumes the cpu model drives mask, restore and take strobes
`timescale 1ns/10ps
module ext_interrupt_edge_and_ack_bench;
  import eie_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, cfg = 1'b0;
  logic       isr = 1'b0, nest = 1'b0, ack, mask, ccr, irq, rf;
  logic [3:0] pin = 4'hF, en = 4'hF, clr = 4'h0, vec, pend;
  logic [7:0] sens = 8'h6A, lvl = 8'h08;
  logic [1:0] cur = 2'h0;
  int         err_total = 0;
  int         cmp_count = 0;
  always #12.5 clk = ~clk;
  eie_top dut_u (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PIN_I(pin),
    .PIN_SENS_I(sens), .PORT_CFG_ACCESS_I(cfg), .SRC_EN_I(en),
    .SRC_LVL_I(lvl), .FLAG_CLR_I(clr), .GLOBAL_MASK_I(mask),
    .CC_RESTORE_I(ccr), .IN_ISR_I(isr), .NESTED_MODE_I(nest),
    .CUR_LVL_I(cur), .VEC_ACK_I(ack), .IRQ_O(irq), .VEC_O(vec),
    .PEND_O(pend), .RESET_FETCH_O(rf));
  eie_cpu_model cpu_u (.clk_i(clk), .irq_i(irq), .ack_o(ack),
    .mask_o(mask), .cc_rst_o(ccr));
  // ======================================
  // helpers
  task chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task clrp(input logic [3:0] m);
    clr = m;
    cyc(1);
    clr = 4'h0;
    cyc(1);
  endtask
  task close_out;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ======================================
  // scenarios
  task s_walk;
    pin[0] = 1'b0;
    cyc(3);
    chk("pend", pend, 4'h1);
    chk("irq", 4'(irq), 4'h1);
    chk("vec", vec, EIE_VEC_BASE);
    cpu_u.take_vector;
    chk("irq_ack", 4'(irq), 4'h0);
    clrp(4'h1);
    cpu_u.set_mask(1'b0);
    pin[0] = 1'b1;
    cyc(3);
    chk("pend_rise", pend, 4'h0);
    chk("irq_done", 4'(irq), 4'h0);
  endtask
  task s_blank;
    cfg    = 1'b1;
    pin[1] = 1'b0;
    cyc(1);
    cfg    = 1'b0;
    pin[2] = 1'b0;
    cyc(3);
    chk("pend_blank", pend, 4'h4);
    pin = 4'hF;
    cyc(2);
    clrp(4'hF);
  endtask
  task s_sens;
    pin[3] = 1'b0;
    cyc(3);
    chk("pend_fall", pend, 4'h0);
    pin[3] = 1'b1;
    cyc(3);
    chk("pend_rise", pend, 4'h8);
    clrp(4'hF);
    sens[7:6] = 2'h3;
    pin[3]    = 1'b0;
    cyc(2);
    chk("pend_both", pend, 4'h8);
    clrp(4'hF);
    chk("pend_both_clr", pend, 4'h0);
    sens[7:6] = 2'h0;
    cpu_u.set_mask(1'b1);
    cyc(1);
    chk("pend_low", pend, 4'h8);
    clr = 4'h8;
    cyc(1);
    clr = 4'h0;
    chk("pend_low_clr", pend, 4'h8);
    chk("fetch_low_clr", 4'(rf), 4'h0);
    pin[3] = 1'b1;
    cyc(1);
    clrp(4'hF);
    cpu_u.set_mask(1'b0);
    chk("pend_low_done", pend, 4'h0);
    sens[7:6] = 2'h1;
  endtask
  task s_mask;
    cpu_u.set_mask(1'b1);
    pin[0] = 1'b0;
    cyc(3);
    chk("pend_mask", pend, 4'h1);
    chk("irq_mask", 4'(irq), 4'h0);
    cpu_u.set_mask(1'b0);
    cyc(3);
    chk("irq_unmask", 4'(irq), 4'h1);
    cpu_u.restore_cc(1'b0);
    chk("fetch", 4'(rf), 4'h1);
    chk("vec_fetch", vec, EIE_RESET_VEC);
    cpu_u.restore_cc(1'b1);
    chk("fetch_guard", 4'(rf), 4'h0);
    pin[0] = 1'b1;
    cyc(2);
    clrp(4'hF);
  endtask
  task hz(input logic c, e, i, n, input logic [1:0] l, input logic x);
    en[1] = e;
    isr   = i;
    nest  = n;
    cur   = l;
    cyc(1);
    pin[1] = 1'b0;
    clr[1] = c;
    cyc(1);
    clr = 4'h0;
    chk("fetch_clr", 4'(rf), 4'(x));
    pin[1] = 1'b1;
    en     = 4'hF;
    cyc(2);
    clrp(4'hF);
  endtask
  // ======================================
  // main sequence and watchdog
  initial begin
    cyc(12);
    rst = 1'b0;
    chk("vec_rst", vec, EIE_RESET_VEC);
    s_walk;
    s_blank;
    s_sens;
    s_mask;
    hz(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1);
    hz(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
    hz(1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
    hz(1'b1, 1'b1, 1'b1, 1'b1, 2'h2, 1'b0);
    hz(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
    close_out;
  end
  initial begin
    #50000;
    err_total++;
    close_out;
  end
endmodule
